// ==== rtl/bmc_pkg.sv ====
package bmc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_THRESH     = 4'h1;
  localparam logic [3:0] ADDR_LEVEL_CTRL = 4'h8;
  localparam logic [3:0] ADDR_IRQ_CTRL   = 4'h9;
  localparam logic [3:0] ADDR_FLAGS      = 4'hA;
  localparam logic [3:0] ADDR_STATE      = 4'hB;
  localparam logic [3:0] ADDR_UNLOCK     = 4'hC;

  // ---------------------------------------------------------------
  // Fields and keys
  // ---------------------------------------------------------------
  localparam int         SAMPLE_RATE_BIT  = 4;
  localparam int         ACTIVE_LSB       = 2;
  localparam int         SLEEP_LSB        = 0;
  localparam int         DIR_LSB          = 1;
  localparam int         IRQ_EN_BIT       = 0;
  localparam int         FLAG_BIT         = 0;
  localparam int         LEVEL_LSB        = 0;
  localparam logic [7:0] UNLOCK_KEY       = 8'hD8;
  localparam logic [2:0] UNLOCK_WINDOW    = 3'h4;
  localparam logic [1:0] SLEEP_RESERVED   = 2'h3;
  localparam logic [7:0] REG_ZERO         = 8'h00;

  // ---------------------------------------------------------------
  // Modes and directions
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_ON      = 2'h1;
  localparam logic [1:0] MODE_SAMPLED = 2'h2;
  localparam logic [1:0] MODE_ON_WAIT = 2'h3;
  localparam logic [1:0] DIR_FALL     = 2'h0;
  localparam logic [1:0] DIR_RISE     = 2'h1;
  localparam logic [1:0] DIR_BOTH     = 2'h2;

  typedef enum logic {BMC_AWAKE, BMC_ASLEEP} bmc_power_e;

  typedef struct packed {
    logic       sample_rate_select;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] trip_threshold_code;
  } bmc_fuse_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bmc_bus_s;

endpackage

// ==== rtl/bmc_control.sv ====
// Behaviour
// - Active mode field loaded from fuse in the first cycle after reset release (reset loads off); software writes ignored.
// - Sleep mode field from fuse, software-writable only after unlock.
// - Entering standby or power-down applies the sleep mode.
// - Waking applies the active mode again.
// - Unlock key write opens protected write for four instructions only.
// - Protected write without unlock is accepted but changes nothing.
// - Read-only bit 4 selects 1kHz sampling at 0, 125Hz at 1.
// - Active mode codes: off, on, sampled, on with wake held until ready.
// - Sleep mode codes: off, on, sampled; code 3 reserved.
// - Read-only threshold code bits 2:0 loaded from fuse.
// - Warning level code sets 5, 15 or 25 percent above threshold.
// - Direction 0 falling, 1 rising, 2 either crossing; others reserved.
// - Interrupt enable bit 0 enables the warning interrupt.
// - Flag set on matching crossing, updated only while detector enabled.
// - Status reads 1 below warning level, valid only while enabled.
// - Monitor follows detector mode: off stays off, sampled is sampled.
// - Interrupt asserted while flag and enable set, until flag cleared.
`timescale 1ns/1ps
module bmc_control (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire bmc_pkg::bmc_bus_s bus_i,
  output logic [7:0]             rdata_o,
  input  wire bmc_pkg::bmc_fuse_s fuse_i,
  input  wire logic              sleep_req_i,
  input  wire logic              below_warning_i,
  input  wire logic              sample_tick_i,
  input  wire logic              detector_ready_i,
  output logic [1:0]             detector_mode_o,
  output logic                   sample_rate_select_o,
  output logic [2:0]             trip_threshold_code_o,
  output logic [1:0]             warning_level_code_o,
  output logic                   wake_hold_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       below_prev_reg;
  logic       warm_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {sleep_req_i, below_warning_i, sample_tick_i};
      sync2_reg <= sync1_reg;
    end
  end
  wire sleep_s = sync2_reg[2];
  wire below_s = sync2_reg[1];
  wire tick_s  = sync2_reg[0];

  // ---------------------------------------------------------------
  // Fuse capture after reset release
  // ---------------------------------------------------------------
  logic       loaded_reg;
  logic       rate_reg;
  logic [1:0] active_reg;
  logic [1:0] sleep_mode_reg;
  logic [2:0] thresh_reg;
  logic [2:0] unlock_cnt_reg;
  logic       ready_s1_reg;
  logic       ready_s2_reg;

  wire wr_ctrl   = bus_i.wr && bus_i.addr == bmc_pkg::ADDR_MODE_CTRL;
  wire unlocked  = unlock_cnt_reg != 3'h0;
  wire [1:0] new_sleep = bus_i.wdata[bmc_pkg::SLEEP_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      loaded_reg <= 1'b0;
      rate_reg   <= 1'b0;
      active_reg <= bmc_pkg::MODE_OFF;
      thresh_reg <= 3'h0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      rate_reg   <= fuse_i.sample_rate_select;
      active_reg <= fuse_i.active_mode;
      thresh_reg <= fuse_i.trip_threshold_code;
    end
  end

  // Unlock window counted in bus cycles, one per instruction
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      unlock_cnt_reg <= 3'h0;
    end else if (bus_i.wr && bus_i.addr == bmc_pkg::ADDR_UNLOCK &&
                 bus_i.wdata == bmc_pkg::UNLOCK_KEY) begin
      unlock_cnt_reg <= bmc_pkg::UNLOCK_WINDOW;
    end else if (wr_ctrl) begin
      unlock_cnt_reg <= 3'h0;
    end else if (unlocked) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sleep_mode_reg <= bmc_pkg::MODE_OFF;
    end else if (!loaded_reg) begin
      sleep_mode_reg <= fuse_i.sleep_mode;
    end else if (wr_ctrl && unlocked && new_sleep != bmc_pkg::SLEEP_RESERVED) begin
      sleep_mode_reg <= new_sleep;
    end
  end

  // ---------------------------------------------------------------
  // Effective detector mode
  // ---------------------------------------------------------------
  bmc_pkg::bmc_power_e power_reg;
  logic [1:0] mode_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      power_reg <= bmc_pkg::BMC_AWAKE;
    end else begin
      case (power_reg)
        bmc_pkg::BMC_AWAKE:  if (sleep_s) power_reg <= bmc_pkg::BMC_ASLEEP;
        bmc_pkg::BMC_ASLEEP: if (!sleep_s) power_reg <= bmc_pkg::BMC_AWAKE;
        default:             power_reg <= bmc_pkg::BMC_AWAKE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_reg <= bmc_pkg::MODE_OFF;
    end else if (power_reg == bmc_pkg::BMC_ASLEEP) begin
      mode_reg <= sleep_mode_reg;
    end else begin
      mode_reg <= active_reg;
    end
  end

  wire det_on  = mode_reg != bmc_pkg::MODE_OFF;
  wire sampled = mode_reg == bmc_pkg::MODE_SAMPLED;
  // Sampled mode only looks at the supply on a sample tick
  wire look    = det_on && (!sampled || tick_s);

  // ---------------------------------------------------------------
  // Warning monitor
  // ---------------------------------------------------------------
  logic [1:0] level_reg;
  logic [1:0] dir_reg;
  logic       irq_en_reg;
  logic       flag_reg;
  logic       state_reg;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      level_reg <= 2'h0;
    end else if (bus_i.wr && bus_i.addr == bmc_pkg::ADDR_LEVEL_CTRL) begin
      level_reg <= bus_i.wdata[bmc_pkg::LEVEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      dir_reg    <= bmc_pkg::DIR_FALL;
      irq_en_reg <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == bmc_pkg::ADDR_IRQ_CTRL) begin
      dir_reg    <= bus_i.wdata[bmc_pkg::DIR_LSB +: 2];
      irq_en_reg <= bus_i.wdata[bmc_pkg::IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg      <= 1'b0;
      below_prev_reg <= 1'b0;
      warm_reg       <= 1'b0;
    end else if (!det_on) begin
      warm_reg <= 1'b0;
    end else if (look) begin
      state_reg      <= below_s;
      below_prev_reg <= below_s;
      warm_reg       <= 1'b1;
    end
  end

  wire fell  = warm_reg && below_s && !below_prev_reg;
  wire rose  = warm_reg && !below_s && below_prev_reg;
  logic hit;
  always_comb begin
    case (dir_reg)
      bmc_pkg::DIR_FALL: hit = fell;
      bmc_pkg::DIR_RISE: hit = rose;
      bmc_pkg::DIR_BOTH: hit = fell || rose;
      default:           hit = 1'b0;
    endcase
  end
  // Monitor inactive unless enabled; detector off blocks it too
  wire event_set = look && irq_en_reg && hit;
  wire flag_clr  = bus_i.wr && bus_i.addr == bmc_pkg::ADDR_FLAGS &&
                   bus_i.wdata[bmc_pkg::FLAG_BIT];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flag_reg <= 1'b0;
    end else if (event_set) begin
      flag_reg <= 1'b1; // set wins over clear
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
    end else begin
      ready_s1_reg <= detector_ready_i;
      ready_s2_reg <= ready_s1_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_o                 <= 1'b0;
      detector_mode_o       <= bmc_pkg::MODE_OFF;
      sample_rate_select_o  <= 1'b0;
      trip_threshold_code_o <= 3'h0;
      warning_level_code_o  <= 2'h0;
      wake_hold_o           <= 1'b0;
    end else begin
      // Tracks the flag's next value, so a set beside a clear never drops it
      irq_o                 <= (event_set || (flag_reg && !flag_clr)) && irq_en_reg;
      detector_mode_o       <= mode_reg;
      sample_rate_select_o  <= rate_reg;
      trip_threshold_code_o <= thresh_reg;
      warning_level_code_o  <= level_reg;
      wake_hold_o           <= active_reg == bmc_pkg::MODE_ON_WAIT && !ready_s2_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= bmc_pkg::REG_ZERO;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        bmc_pkg::ADDR_MODE_CTRL:  rdata_o <= {3'h0, rate_reg, active_reg, sleep_mode_reg};
        bmc_pkg::ADDR_THRESH:     rdata_o <= {5'h00, thresh_reg};
        bmc_pkg::ADDR_LEVEL_CTRL: rdata_o <= {6'h00, level_reg};
        bmc_pkg::ADDR_IRQ_CTRL:   rdata_o <= {5'h00, dir_reg, irq_en_reg};
        bmc_pkg::ADDR_FLAGS:      rdata_o <= {7'h00, flag_reg};
        bmc_pkg::ADDR_STATE:      rdata_o <= {7'h00, state_reg && det_on};
        default:                  rdata_o <= bmc_pkg::REG_ZERO;
      endcase
    end else begin
      rdata_o <= bmc_pkg::REG_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Locked write: key missing or window already run out
  sequence s_locked_write;
    loaded_reg && !unlocked && wr_ctrl;
  endsequence

  sequence s_unlock_key;
    bus_i.wr && bus_i.addr == bmc_pkg::ADDR_UNLOCK && bus_i.wdata == bmc_pkg::UNLOCK_KEY;
  endsequence

  a_locked_sleep_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_locked_write |=> $stable(sleep_mode_reg))
    else $error("sleep mode changed without unlock");
  a_active_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(loaded_reg) |-> $stable(active_reg))
    else $error("active mode changed after load");
  a_unlock_window: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_unlock_key ##1 !(bus_i.wr) [*4] |=> !unlocked)
    else $error("unlock window too long");
  a_unlock_open: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_unlock_key |=> unlocked)
    else $error("unlock key did not open window");
  a_unlock_last: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_unlock_key ##1 !(bus_i.wr) [*3] |=> unlocked)
    else $error("unlock window too short");
  a_unlock_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    loaded_reg && unlocked && wr_ctrl && new_sleep != bmc_pkg::SLEEP_RESERVED
    |=> sleep_mode_reg == $past(new_sleep))
    else $error("unlocked sleep write lost");
  a_sleep_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
    loaded_reg && wr_ctrl && new_sleep == bmc_pkg::SLEEP_RESERVED
    |=> $stable(sleep_mode_reg))
    else $error("reserved sleep code stored");
  a_sleep_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    power_reg == bmc_pkg::BMC_ASLEEP |=> mode_reg == $past(sleep_mode_reg))
    else $error("sleep mode not applied");
  a_wake_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    power_reg == bmc_pkg::BMC_AWAKE |=> mode_reg == $past(active_reg))
    else $error("active mode not restored");
  a_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    event_set |=> flag_reg)
    else $error("event flag not set");
  a_flag_off_det: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !det_on && !flag_reg |=> !flag_reg)
    else $error("flag set with detector off");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    flag_clr && !event_set |=> !flag_reg)
    else $error("flag not cleared");
  a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    flag_reg && irq_en_reg ##1 flag_reg && irq_en_reg |-> irq_o)
    else $error("irq not asserted");
  a_irq_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o |-> $past(irq_en_reg))
    else $error("irq without enable");

  // ---------------------------------------------------------------
  // Checks on fuse fields, power state and outputs
  // ---------------------------------------------------------------
  a_fuse_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(loaded_reg) |-> $stable(rate_reg) && $stable(thresh_reg))
    else $error("fuse field changed after load");
  a_thresh_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_i.rd && bus_i.addr == bmc_pkg::ADDR_THRESH |=> rdata_o == {5'h00, $past(thresh_reg)})
    else $error("threshold read wrong");
  a_hold_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
    active_reg == bmc_pkg::MODE_ON_WAIT && !ready_s2_reg |=> wake_hold_o)
    else $error("wake not held for detector");
  a_hold_ready: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ready_s2_reg |=> !wake_hold_o)
    else $error("wake held after detector ready");
  a_mode_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> detector_mode_o == $past(mode_reg))
    else $error("detector mode output stale");
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sleep_s && power_reg == bmc_pkg::BMC_AWAKE |=> power_reg == bmc_pkg::BMC_ASLEEP)
    else $error("sleep request not taken");
  a_wake_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !sleep_s && power_reg == bmc_pkg::BMC_ASLEEP |=> power_reg == bmc_pkg::BMC_AWAKE)
    else $error("wake request not taken");

  // ---------------------------------------------------------------
  // Checks on the warning monitor
  // ---------------------------------------------------------------
  a_level_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_i.wr && bus_i.addr == bmc_pkg::ADDR_LEVEL_CTRL
    |=> level_reg == $past(bus_i.wdata[bmc_pkg::LEVEL_LSB +: 2]))
    else $error("level code not stored");
  a_dir_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_i.wr && bus_i.addr == bmc_pkg::ADDR_IRQ_CTRL
    |=> dir_reg == $past(bus_i.wdata[bmc_pkg::DIR_LSB +: 2]))
    else $error("direction not stored");
  a_enable_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !irq_en_reg && !flag_reg |=> !flag_reg)
    else $error("flag set with monitor disabled");
  a_sampled_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampled && !tick_s && !flag_reg |=> !flag_reg)
    else $error("sampled monitor looked between ticks");
  a_state_track: assert property (@(posedge clk_i) disable iff (!rstn_i)
    look |=> state_reg == $past(below_s))
    else $error("status missed a look");
  a_status_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_i.rd && bus_i.addr == bmc_pkg::ADDR_STATE && !det_on
    |=> rdata_o == bmc_pkg::REG_ZERO)
    else $error("status read with detector off");
  a_flag_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    flag_reg && !flag_clr |=> flag_reg)
    else $error("flag dropped without clear");
  a_irq_drop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !flag_reg && !event_set |=> !irq_o)
    else $error("irq without flag");

endmodule

// ==== tb/brownout_monitor_control_tb_top.sv ====
`timescale 1ns/1ps
module brownout_monitor_control_tb_top;
  // ---------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------
  logic               clk_i;
  logic               rstn_i;
  bmc_pkg::bmc_bus_s  bus;
  bmc_pkg::bmc_fuse_s fuse;
  logic               sleep_req;
  logic               below;
  logic               tick;
  logic               ready;
  logic [7:0]         rdata;
  logic [1:0]         mode;
  logic               rate;
  logic [2:0]         thr;
  logic [1:0]         lvl;
  logic               hold;
  logic               irq;
  logic [7:0]         d;
  int                 mismatches;
  int                 num_checks;
  int                 cycles;
  // Rows: address, write data, expected read back
  logic [3:0]         row_a [6] = '{4'h8, 4'h9, 4'hB, 4'h5, 4'h1, 4'hA};
  logic [7:0]         row_w [6] = '{8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]         row_e [6] = '{8'h03, 8'h06, 8'h00, 8'h00, 8'h07, 8'h00};

  bmc_control dut (
    .clk_i                 (clk_i),
    .rstn_i                (rstn_i),
    .bus_i                 (bus),
    .rdata_o               (rdata),
    .fuse_i                (fuse),
    .sleep_req_i           (sleep_req),
    .below_warning_i       (below),
    .sample_tick_i         (tick),
    .detector_ready_i      (ready),
    .detector_mode_o       (mode),
    .sample_rate_select_o  (rate),
    .trip_threshold_code_o (thr),
    .warning_level_code_o  (lvl),
    .wake_hold_o           (hold),
    .irq_o                 (irq)
  );

  always #25 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Gap cycle after each strobe keeps every strobe one cycle long
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk_i);
    bus.addr  <= a;
    bus.wdata <= w;
    bus.wr    <= 1'b1;
    @(posedge clk_i);
    bus.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_i);
    bus.rd   <= 1'b0;
    #1 r = rdata;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    bus = '0;
    fuse = '{sample_rate_select: 1'b1, active_mode: 2'h1, sleep_mode: 2'h2,
             trip_threshold_code: 3'h7};
    sleep_req = 1'b0;
    below = 1'b0;
    tick = 1'b1;
    ready = 1'b1;
    wait_n(3);
    chk({irq, hold, lvl, thr, rate}, 8'h00);
    rstn_i <= 1'b1;
    wait_n(8);
    chk({5'h0, thr}, 8'h07);
    chk({6'h0, mode}, 8'h01);
    chk({7'h0, rate}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(row_a[i], row_w[i]);
      rd(row_a[i], d);
      chk(d, row_e[i]);
    end
    chk({6'h0, lvl}, 8'h03);
    rd(4'h0, d);
    chk(d, 8'h16);
    wr(4'h0, 8'hFF);
    rd(4'h0, d);
    chk(d, 8'h16);
    wr(4'hC, 8'hD8);
    wait_n(6);
    wr(4'h0, 8'h00);
    rd(4'h0, d);
    chk(d, 8'h16);
    wr(4'hC, 8'hD8);
    wr(4'h0, 8'h03);
    rd(4'h0, d);
    chk(d, 8'h16);
    wr(4'hC, 8'hD8);
    wr(4'h0, 8'h00);
    rd(4'h0, d);
    chk(d, 8'h14);
    // Sleep field now off, so the monitor must go quiet in sleep
    wr(4'h9, 8'h01);
    sleep_req <= 1'b1;
    wait_n(10);
    chk({6'h0, mode}, 8'h00);
    below <= 1'b1;
    wait_n(10);
    rd(4'hB, d);
    chk(d, 8'h00);
    sleep_req <= 1'b0;
    wait_n(10);
    chk({6'h0, mode}, 8'h01);
    rd(4'hA, d);
    chk(d, 8'h00);
    below <= 1'b0;
    wait_n(10);
    wr(4'hA, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(4'h9, {5'h0, k[1:0], 1'b1});
      below <= 1'b1;
      wait_n(10);
      rd(4'hA, d);
      chk(d, {7'h0, k != 1});
      chk({7'h0, irq}, {7'h0, k != 1});
      wr(4'hA, 8'h01);
      below <= 1'b0;
      wait_n(10);
      rd(4'hA, d);
      chk(d, {7'h0, k != 0});
      wr(4'hA, 8'h01);
    end
    wr(4'h9, 8'h01);
    below <= 1'b1;
    wait_n(10);
    rd(4'hB, d);
    chk(d, 8'h01);
    wr(4'hA, 8'h00);
    rd(4'hA, d);
    chk(d, 8'h01);
    wr(4'h9, 8'h00);
    wait_n(2);
    chk({7'h0, irq}, 8'h00);
    wr(4'hA, 8'h01);
    rd(4'hA, d);
    chk(d, 8'h00);
    // Sampled sleep mode only looks at the supply on a tick
    wr(4'hC, 8'hD8);
    wr(4'h0, 8'h02);
    rd(4'h0, d);
    chk(d, 8'h16);
    wr(4'h9, 8'h03);
    tick      <= 1'b0;
    sleep_req <= 1'b1;
    wait_n(10);
    chk({6'h0, mode}, 8'h02);
    below <= 1'b0;
    wait_n(10);
    rd(4'hA, d);
    chk(d, 8'h00);
    wait_n(1);
    tick <= 1'b1;
    wait_n(1);
    tick <= 1'b0;
    wait_n(6);
    rd(4'hA, d);
    chk(d, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(4'hA, 8'h01);
    tick      <= 1'b1;
    sleep_req <= 1'b0;
    wait_n(10);
    chk({6'h0, mode}, 8'h01);
    // Second reset with the wait-for-ready active mode
    below <= 1'b0;
    fuse.active_mode <= 2'h3;
    ready <= 1'b0;
    rstn_i <= 1'b0;
    wait_n(3);
    rstn_i <= 1'b1;
    wait_n(8);
    chk({6'h0, mode}, 8'h03);
    chk({7'h0, hold}, 8'h01);
    ready <= 1'b1;
    wait_n(8);
    chk({7'h0, hold}, 8'h00);
    tally_and_finish;
  end
endmodule
